/* hw/lpm_pkg.sv */
// Purpose: constants and types shared by the low power mode controller
// Assumes: one clock domain; interrupt requests arrive already latched on that clock
// Notes: wake source bit order is timebase, ext0..ext3, sync serial, timer a, timer b, async serial, voltage det
//
// Function
// - wait instruction stops cpu clock, all peripherals stay clocked.
// - during wait the interrupt mask field is forced to binary 10.
// - wait entry changes nothing except the interrupt mask field.
// - wait ends on any interrupt or reset, then that routine is entered.
// - on servicing, stack condition codes, load routine priority, restore on pop.
// - halt instruction enters active halt if oscillator irq enable set, else halt.
// - active halt ends only on timebase, wake-capable interrupt or reset.
// - interrupt exit from active halt skips start-up delay, services immediately.
// - reset exit applies start-up delay before reset vector fetch.
// - halt entries force mask to 10b; pending interrupt wakes at once.
// - active halt runs only oscillator and timebase counter.
// - oscillator irq enable set means active halt never causes watchdog reset.
// - halt ends on wake-capable interrupt or reset, oscillator restarts, delay waits.
// - halt switches oscillator off and stops cpu and peripherals.
// - watchdog-halt option sets whether halt with watchdog running resets.
// - opcode 0x8E is decoded as the halt instruction.
// - wait entered in slow mode becomes slow-wait, keeping clock division.
// - only four external lines and sync serial wake from halt; timebase also wakes active halt.

package lpm_pkg;

   // ==========================================================
   // instruction decode
   localparam logic [7:0] HALT_OPCODE = 8'h8E;

   // ==========================================================
   // interrupt sources
   localparam int NUM_IRQ = 10;
   localparam logic [9:0] WAKE_HALT_MASK = 10'h03F;   // timebase, ext0..3, sync serial
   localparam logic [9:0] TIMEBASE_BIT = 10'h001;

   // ==========================================================
   // condition code mask field
   localparam logic [1:0] MASK_ALL_ENABLED = 2'h2;
   localparam logic [1:0] MASK_RESET_VALUE = 2'h3;

   // ==========================================================
   // start-up delay in cpu cycles
   localparam int STARTUP_SHORT_CYC = 256;
   localparam int STARTUP_LONG_CYC = 4096;
   localparam int STARTUP_CNT_W = 13;
   localparam logic [12:0] STARTUP_CNT_RESET = 13'h0000;

   // ==========================================================
   // power modes
   typedef enum logic [2:0] {
      MODE_RUN = 3'b000,
      MODE_WAIT = 3'b001,
      MODE_ACTIVE_HALT = 3'b010,
      MODE_HALT = 3'b011,
      MODE_STARTUP = 3'b100,
      MODE_HALT_REMAIN = 3'b101
   } lpm_mode_t;

endpackage : lpm_pkg

/* hw/low_power_mode_controller.sv */
// Purpose: power mode sequencing for the cpu core, oscillator and peripheral clock gates
// Assumes: cpu presents decoded instruction strobes; interrupt requests are level, same clock
// Notes: clock gate outputs are registered enables, the clock tree applies them

`timescale 1ns/1ps
`default_nettype none

module low_power_mode_controller #(
   parameter int SHORT_CYC = lpm_pkg::STARTUP_SHORT_CYC,
   parameter int LONG_CYC = lpm_pkg::STARTUP_LONG_CYC
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_instr_valid,
   input wire logic [7:0] i_instr_opcode,
   input wire logic i_wait_for_interrupt_instr,
   input wire logic i_osc_irq_enable,
   input wire logic i_slow_mode,
   input wire logic i_long_startup,
   input wire logic i_watchdog_active,
   input wire logic i_watchdog_halt_option,
   input wire logic [9:0] i_irq_req,
   input wire logic [1:0] i_irq_sw_prio,
   input wire logic i_cc_mask_we,
   input wire logic [1:0] i_cc_mask_wdata,
   output logic [2:0] o_mode,
   output logic o_cpu_clk_en,
   output logic o_periph_clk_en,
   output logic o_timebase_clk_en,
   output logic o_osc_en,
   output logic o_slow_wait,
   output logic [1:0] o_cc_mask,
   output logic o_cc_push,
   output logic o_irq_service,
   output logic [3:0] o_irq_index,
   output logic o_reset_vector_fetch,
   output logic o_watchdog_reset_req
);

   // ==========================================================
   // helpers

   // lowest index wins: timebase has the highest priority
   function automatic logic [3:0] first_irq(input logic [9:0] req);
      logic [3:0] idx;
      idx = 4'h0;
      for (int k = lpm_pkg::NUM_IRQ - 1; k >= 0; k--) begin
         if (req[k]) begin
            idx = 4'(k);
         end
      end
      return idx;
   endfunction : first_irq

   // clock gates per mode: cpu, peripherals, timebase, oscillator
   function automatic logic [3:0] mode_gates(input lpm_pkg::lpm_mode_t m);
      logic [3:0] g;
      g = 4'h0;
      case (m)
         lpm_pkg::MODE_RUN: g = 4'hF;
         lpm_pkg::MODE_WAIT: g = 4'h7;          // cpu off, peripherals on
         lpm_pkg::MODE_ACTIVE_HALT: g = 4'h3;   // only oscillator and timebase
         lpm_pkg::MODE_HALT: g = 4'h0;          // oscillator off, all stopped
         lpm_pkg::MODE_STARTUP: g = 4'h1;       // oscillator restarts at once
         lpm_pkg::MODE_HALT_REMAIN: g = 4'h0;
         default: g = 4'h0;
      endcase
      return g;
   endfunction : mode_gates

   // ==========================================================
   // decode and wake qualification
   localparam logic [12:0] SHORT_LAST = 13'(SHORT_CYC - 1);
   localparam logic [12:0] LONG_LAST = 13'(LONG_CYC - 1);

   // sequencing state, counters and decoded events
   lpm_pkg::lpm_mode_t mode_q;
   lpm_pkg::lpm_mode_t mode_d;
   logic [12:0] cnt_q;
   logic [12:0] cnt_d;
   logic [12:0] cnt_last;
   logic guard_q;
   logic guard_d;
   logic svc_pend_q;
   logic svc_pend_d;
   logic [3:0] svc_idx_q;
   logic [3:0] svc_idx_d;
   logic halt_exec;
   logic wfi_exec;
   logic any_irq;
   logic halt_wake;
   logic ahalt_wake;
   logic wdg_trip;
   logic cnt_done;
   logic service_now;
   logic vector_now;
   logic [3:0] gates_d;
   logic enter_low;

   // instruction strobes from the cpu core and wake qualification
   assign halt_exec = i_instr_valid && (i_instr_opcode == lpm_pkg::HALT_OPCODE);
   assign wfi_exec = i_instr_valid && i_wait_for_interrupt_instr;
   assign any_irq = |i_irq_req;
   assign halt_wake = |(i_irq_req & lpm_pkg::WAKE_HALT_MASK & ~lpm_pkg::TIMEBASE_BIT);
   assign ahalt_wake = |(i_irq_req & lpm_pkg::WAKE_HALT_MASK);
   // watchdog reset only in full halt with the watchdog running and the option clear
   assign wdg_trip = halt_exec && i_watchdog_active && !i_osc_irq_enable && !i_watchdog_halt_option;
   // a halt or wait really taken; outside run the cpu is stopped and issues nothing
   assign enter_low = (mode_q == lpm_pkg::MODE_RUN) && ((halt_exec && !wdg_trip) || wfi_exec);
   // last count of the start-up window, picked by a static input
   assign cnt_last = i_long_startup ? LONG_LAST : SHORT_LAST;
   assign cnt_done = (cnt_q == cnt_last);

   // ==========================================================
   // mode sequencing
   always_comb begin
      mode_d = mode_q;
      cnt_d = cnt_q;
      guard_d = guard_q;
      svc_pend_d = svc_pend_q;
      svc_idx_d = svc_idx_q;
      service_now = 1'b0;
      vector_now = 1'b0;
      case (mode_q)
         lpm_pkg::MODE_RUN: begin
            if (guard_q) begin
               // delay window after an active halt wake
               cnt_d = cnt_q + 13'h0001;
               if (cnt_done) begin
                  guard_d = 1'b0;
                  cnt_d = lpm_pkg::STARTUP_CNT_RESET;
               end else if (!i_osc_irq_enable) begin
                  mode_d = lpm_pkg::MODE_HALT_REMAIN;
               end
            end
            if (wdg_trip) begin
               mode_d = lpm_pkg::MODE_RUN;  // reset request issued instead of halting
            end else if (halt_exec) begin
               guard_d = 1'b0;
               cnt_d = lpm_pkg::STARTUP_CNT_RESET;
               if (any_irq) begin
                  service_now = 1'b1;  // pending request served at once, mask loads routine priority
                  svc_idx_d = first_irq(i_irq_req);
                  mode_d = lpm_pkg::MODE_RUN;
               end else if (i_osc_irq_enable) begin
                  mode_d = lpm_pkg::MODE_ACTIVE_HALT;
               end else begin
                  mode_d = lpm_pkg::MODE_HALT;
               end
            end else if (wfi_exec) begin
               if (any_irq) begin
                  service_now = 1'b1;
                  svc_idx_d = first_irq(i_irq_req);
               end else begin
                  mode_d = lpm_pkg::MODE_WAIT;
               end
            end
         end
         lpm_pkg::MODE_WAIT: begin
            // any request wakes wait, the mask is already open
            if (any_irq) begin
               service_now = 1'b1;
               svc_idx_d = first_irq(i_irq_req);
               mode_d = lpm_pkg::MODE_RUN;
            end
         end
         lpm_pkg::MODE_ACTIVE_HALT: begin
            if (ahalt_wake) begin
               // no start-up delay, the oscillator never stopped
               service_now = 1'b1;
               svc_idx_d = first_irq(i_irq_req & lpm_pkg::WAKE_HALT_MASK);
               mode_d = lpm_pkg::MODE_RUN;
               guard_d = 1'b1;
               cnt_d = lpm_pkg::STARTUP_CNT_RESET;
            end
         end
         lpm_pkg::MODE_HALT: begin
            // wake source is kept until the oscillator has settled
            if (halt_wake) begin
               svc_pend_d = 1'b1;
               svc_idx_d = first_irq(i_irq_req & lpm_pkg::WAKE_HALT_MASK);
               cnt_d = lpm_pkg::STARTUP_CNT_RESET;
               mode_d = lpm_pkg::MODE_STARTUP;
            end
         end
         lpm_pkg::MODE_STARTUP: begin
            // oscillator stabilisation before any code runs
            cnt_d = cnt_q + 13'h0001;
            if (cnt_done) begin
               cnt_d = lpm_pkg::STARTUP_CNT_RESET;
               mode_d = lpm_pkg::MODE_RUN;
               svc_pend_d = 1'b0;
               if (svc_pend_q) begin
                  service_now = 1'b1;
               end else begin
                  vector_now = 1'b1;
               end
            end
         end
         lpm_pkg::MODE_HALT_REMAIN: begin
            // halted for whatever is left of the delay window
            cnt_d = cnt_q + 13'h0001;
            if (cnt_done) begin
               cnt_d = lpm_pkg::STARTUP_CNT_RESET;
               guard_d = 1'b0;
               mode_d = lpm_pkg::MODE_RUN;
            end
         end
         default: begin
            mode_d = lpm_pkg::MODE_STARTUP;
            cnt_d = lpm_pkg::STARTUP_CNT_RESET;
         end
      endcase
   end

   // gates follow the next mode so they switch together with o_mode
   assign gates_d = mode_gates(mode_d);

   // ==========================================================
   // state registers; reset always restarts through the delay
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_q <= lpm_pkg::MODE_STARTUP;
         cnt_q <= lpm_pkg::STARTUP_CNT_RESET;
         guard_q <= 1'b0;
         svc_pend_q <= 1'b0;
         svc_idx_q <= 4'h0;
      end else if (i_clk_en) begin
         mode_q <= mode_d;
         cnt_q <= cnt_d;
         guard_q <= guard_d;
         svc_pend_q <= svc_pend_d;
         svc_idx_q <= svc_idx_d;
      end
   end

   // ==========================================================
   // registered clock gates and mode report
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_mode <= lpm_pkg::MODE_STARTUP;
         o_cpu_clk_en <= 1'b0;
         o_periph_clk_en <= 1'b0;
         o_timebase_clk_en <= 1'b0;
         o_osc_en <= 1'b1;
         o_slow_wait <= 1'b0;
      end else if (i_clk_en) begin
         o_mode <= mode_d;
         o_cpu_clk_en <= gates_d[3];
         o_periph_clk_en <= gates_d[2];
         o_timebase_clk_en <= gates_d[1];
         o_osc_en <= gates_d[0];
         o_slow_wait <= (mode_d == lpm_pkg::MODE_WAIT) && i_slow_mode;
      end
   end

   // ==========================================================
   // interrupt mask field of the condition codes
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cc_mask <= lpm_pkg::MASK_RESET_VALUE;
      end else if (i_clk_en) begin
         if (service_now) begin
            o_cc_mask <= i_irq_sw_prio;
         end else if (enter_low || mode_q == lpm_pkg::MODE_WAIT) begin
            o_cc_mask <= lpm_pkg::MASK_ALL_ENABLED;
         end else if (i_cc_mask_we) begin
            o_cc_mask <= i_cc_mask_wdata;  // pop restores stacked value
         end
      end
   end

   // ==========================================================
   // one-cycle strobes to the cpu core and watchdog
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cc_push <= 1'b0;
         o_irq_service <= 1'b0;
         o_irq_index <= 4'h0;
         o_reset_vector_fetch <= 1'b0;
         o_watchdog_reset_req <= 1'b0;
      end else if (i_clk_en) begin
         o_cc_push <= service_now;
         o_irq_service <= service_now;
         o_irq_index <= svc_idx_d;
         o_reset_vector_fetch <= vector_now;
         o_watchdog_reset_req <= wdg_trip;
      end else begin
         // a frozen clock must not stretch a one-cycle strobe
         o_cc_push <= 1'b0;
         o_irq_service <= 1'b0;
         o_reset_vector_fetch <= 1'b0;
         o_watchdog_reset_req <= 1'b0;
      end
   end

   // nothing else in the core is touched by wait or halt entry

endmodule : low_power_mode_controller

`default_nettype wire

/* verif/lpm_irq_src.sv */
// Purpose: interrupt sources beside the power mode controller
// Assumes: requests are raised by one-cycle pulses from the bench
// Notes: a request stays pending until its routine is entered or a flush clears it
`timescale 1ns/1ps
`default_nettype none
module lpm_irq_src (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [9:0] i_raise,
   input wire logic i_flush,
   input wire logic i_service,
   input wire logic [3:0] i_index,
   output logic [9:0] o_req
);
   // ======
   // request latch, cleared on service or flush
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_req <= 10'h000;
      end else if (i_flush) begin
         o_req <= 10'h000;
      end else begin
         o_req <= (o_req | i_raise) & ~(i_service ? (10'h001 << i_index) : 10'h000);
      end
   end
endmodule : lpm_irq_src
`default_nettype wire

/* verif/lpm_sva.sv */
// Purpose: port checks for the power mode controller
// Assumes: one clock, asynchronous reset
// Notes: startup length is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module lpm_sva #(
   parameter int SHORT_CYC = lpm_pkg::STARTUP_SHORT_CYC,
   parameter int LONG_CYC = lpm_pkg::STARTUP_LONG_CYC
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_instr_valid,
   input wire logic [7:0] i_instr_opcode,
   input wire logic i_wait_for_interrupt_instr,
   input wire logic i_osc_irq_enable,
   input wire logic i_long_startup,
   input wire logic i_watchdog_active,
   input wire logic i_watchdog_halt_option,
   input wire logic [9:0] i_irq_req,
   input wire logic [2:0] o_mode,
   input wire logic o_cpu_clk_en,
   input wire logic o_periph_clk_en,
   input wire logic o_timebase_clk_en,
   input wire logic o_osc_en,
   input wire logic [1:0] o_cc_mask,
   input wire logic o_irq_service,
   input wire logic o_watchdog_reset_req
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic [12:0] cnt_q;
   // ======
   // enabled edges spent in startup
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= 13'h0000;
      end else if (i_clk_en) begin
         cnt_q <= (o_mode == 3'h4) ? cnt_q + 13'h0001 : 13'h0000;
      end
   end
   // ======
   // instruction taken in run with nothing pending
   sequence s_run_instr;
      i_clk_en && i_instr_valid && o_mode == 3'h0 && i_irq_req == 10'h000;
   endsequence
   sequence s_halt_instr;
      s_run_instr ##0 i_instr_opcode == lpm_pkg::HALT_OPCODE;
   endsequence
   property p_halt;
      s_halt_instr ##0 (!i_osc_irq_enable && (i_watchdog_halt_option || !i_watchdog_active))
         |=> o_mode == 3'h3 && !o_osc_en && !o_timebase_clk_en && o_cc_mask == 2'h2;
   endproperty
   property p_ahalt;
      s_halt_instr ##0 i_osc_irq_enable
         |=> o_mode == 3'h2 && o_osc_en && o_timebase_clk_en && !o_periph_clk_en && !o_watchdog_reset_req;
   endproperty
   property p_wdog;
      s_halt_instr ##0 (!i_osc_irq_enable && i_watchdog_active && !i_watchdog_halt_option)
         |=> o_watchdog_reset_req && o_mode == 3'h0;
   endproperty
   property p_wait;
      s_run_instr ##0 (i_wait_for_interrupt_instr && i_instr_opcode != lpm_pkg::HALT_OPCODE)
         |=> o_mode == 3'h1 && !o_cpu_clk_en && o_periph_clk_en && o_cc_mask == 2'h2;
   endproperty
   property p_wait_wake;
      o_mode == 3'h1 && i_clk_en && i_irq_req != 10'h000 |=> o_irq_service && o_cpu_clk_en;
   endproperty
   property p_ahalt_wake;
      o_mode == 3'h2 && i_clk_en && i_irq_req[0] |=> o_irq_service && o_mode == 3'h0;
   endproperty
   property p_ahalt_hold;
      o_mode == 3'h2 && i_clk_en && (i_irq_req & lpm_pkg::WAKE_HALT_MASK) == 10'h000 |=> o_mode == 3'h2;
   endproperty
   property p_halt_wake;
      o_mode == 3'h3 && i_clk_en && (i_irq_req & 10'h03E) != 10'h000 |=> o_mode == 3'h4 && o_osc_en;
   endproperty
   property p_startup;
      o_mode == 3'h0 && $past(o_mode) == 3'h4
         |-> cnt_q == (i_long_startup ? LONG_CYC : SHORT_CYC) && o_cpu_clk_en;
   endproperty
   a_halt: assert property (p_halt) else $error("halt entry wrong");
   a_ahalt: assert property (p_ahalt) else $error("active halt entry wrong");
   a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
   a_wait: assert property (p_wait) else $error("wait entry wrong");
   a_wait_wake: assert property (p_wait_wake) else $error("wait wake missing");
   a_ahalt_wake: assert property (p_ahalt_wake) else $error("active halt wake wrong");
   a_ahalt_hold: assert property (p_ahalt_hold) else $error("active halt left early");
   a_halt_wake: assert property (p_halt_wake) else $error("halt wake wrong");
   a_startup: assert property (p_startup) else $error("startup length wrong");
endmodule : lpm_sva
bind low_power_mode_controller lpm_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_sva (
   .i_clock, .i_sys_rst, .i_clk_en, .i_instr_valid, .i_instr_opcode, .i_wait_for_interrupt_instr,
   .i_osc_irq_enable, .i_long_startup, .i_watchdog_active, .i_watchdog_halt_option, .i_irq_req,
   .o_mode, .o_cpu_clk_en, .o_periph_clk_en, .o_timebase_clk_en, .o_osc_en, .o_cc_mask,
   .o_irq_service, .o_watchdog_reset_req);
`default_nettype wire

/* verif/low_power_mode_controller_bench.sv */
// Purpose: self-checking bench for the power mode controller
// Assumes: inputs change on the falling edge, short startup counts
// Notes: expected index is the lowest raised request
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_bench;
   localparam int SC = 4;
   localparam int LC = 8;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_instr_valid = 1'b0, i_wait_for_interrupt_instr = 1'b0, i_cc_mask_we = 1'b0, flush = 1'b0;
   logic i_clk_en = 1'b1;
   logic i_osc_irq_enable = 1'b0, i_slow_mode = 1'b0, i_long_startup = 1'b0;
   logic i_watchdog_active = 1'b0, i_watchdog_halt_option = 1'b0;
   logic [7:0] i_instr_opcode = 8'h00;
   logic [1:0] i_irq_sw_prio = 2'h0, i_cc_mask_wdata = 2'h0;
   logic [9:0] raise = 10'h000, irq, r;
   logic [2:0] o_mode;
   logic [1:0] o_cc_mask;
   logic [3:0] o_irq_index;
   logic o_cpu_clk_en, o_periph_clk_en, o_timebase_clk_en, o_osc_en, o_slow_wait;
   logic o_cc_push, o_irq_service, o_reset_vector_fetch, o_watchdog_reset_req;
   int fails = 0, checks = 0, k;
   int exp_idx[$];
   integer seed = 32'h4DB3;
   // ======
   // clock, design and request source
   always #50 i_clock = ~i_clock;
   low_power_mode_controller #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut (
      .i_clock, .i_sys_rst, .i_clk_en, .i_instr_valid, .i_instr_opcode, .i_wait_for_interrupt_instr,
      .i_osc_irq_enable, .i_slow_mode, .i_long_startup, .i_watchdog_active, .i_watchdog_halt_option,
      .i_irq_req(irq), .i_irq_sw_prio, .i_cc_mask_we, .i_cc_mask_wdata, .o_mode, .o_cpu_clk_en,
      .o_periph_clk_en, .o_timebase_clk_en, .o_osc_en, .o_slow_wait, .o_cc_mask, .o_cc_push,
      .o_irq_service, .o_irq_index, .o_reset_vector_fetch, .o_watchdog_reset_req);
   lpm_irq_src src (.i_clock, .i_sys_rst, .i_raise(raise), .i_flush(flush), .i_service(o_irq_service),
      .i_index(o_irq_index), .o_req(irq));
   // ======
   // compares and drivers
   task automatic cmp_val(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : cmp_val
   task automatic cmp_cyc(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         fails++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmp_cyc
   task automatic instr(input logic [7:0] op, input logic wait_for_interrupt_instr);
      i_instr_valid = 1'b1;
      i_instr_opcode = op;
      i_wait_for_interrupt_instr = wait_for_interrupt_instr;
      @(negedge i_clock);
      i_instr_valid = 1'b0;
      i_wait_for_interrupt_instr = 1'b0;
   endtask : instr
   task automatic wait_run();
      k = 0;
      while (o_cpu_clk_en !== 1'b1 && k < 20) begin
         @(negedge i_clock);
         k++;
      end
   endtask : wait_run
   // raise requests, expect the lowest one serviced after lat cycles
   task automatic wake(input logic [9:0] bits, input int lat);
      logic [3:0] idx;
      logic [1:0] prio;
      idx = 4'h0;
      prio = 2'($random(seed));
      while (bits[idx] !== 1'b1) idx++;
      exp_idx.push_back(int'(idx));  // model: lowest raised source is served first
      i_irq_sw_prio = prio;
      raise = bits;
      k = 0;
      do begin
         @(negedge i_clock);
         raise = 10'h000;
         k++;
      end while (o_irq_service !== 1'b1 && k < 20);
      cmp_cyc("wake latency", lat, k);
      cmp_val("service index", idx, o_irq_index);
      cmp_val("mask after service", {2'h0, prio}, {2'h0, o_cc_mask});
      cmp_val("push", 4'h1, {3'h0, o_cc_push});
      cmp_val("mode after wake", 4'h0, {1'b0, o_mode});
      flush = 1'b1;
      @(negedge i_clock);
      flush = 1'b0;
   endtask : wake
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // ======
   // reference model: every service pulse must match the oldest expected source
   always @(negedge i_clock) begin
      if (o_irq_service === 1'b1) begin
         cmp_val("model service", 4'h1, {3'h0, (exp_idx.size() > 0)});
         if (exp_idx.size() > 0) begin
            cmp_val("model index", 4'(exp_idx.pop_front()), o_irq_index);
         end
      end
   end
   // ======
   // watchdog on the whole run
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
   // ======
   // test sequence
   initial begin
      repeat (3) @(negedge i_clock);
      cmp_val("reset mode", 4'h4, {1'b0, o_mode});
      cmp_val("reset mask", 4'h3, {2'h0, o_cc_mask});
      i_sys_rst = 1'b0;
      wait_run();
      cmp_cyc("reset delay", SC, k);
      cmp_val("vector fetch", 4'h1, {3'h0, o_reset_vector_fetch});
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         r = 10'($random(seed));
         i_slow_mode = r[0];
         instr((r[9:2] == 8'h8E) ? 8'h00 : r[9:2], 1'b1);
         cmp_val("wait mode", 4'h1, {1'b0, o_mode});
         cmp_val("wait clocks", 4'h1, {2'h0, o_cpu_clk_en, o_periph_clk_en});
         cmp_val("wait mask", 4'h2, {2'h0, o_cc_mask});
         cmp_val("slow wait", {3'h0, r[0]}, {3'h0, o_slow_wait});
         wake(10'h001 << i, 2);
      end
      i_slow_mode = 1'b0;
      i_cc_mask_wdata = r[1:0];
      i_cc_mask_we = 1'b1;
      @(negedge i_clock);
      i_cc_mask_we = 1'b0;
      cmp_val("mask write", {2'h0, r[1:0]}, {2'h0, o_cc_mask});
      i_clk_en = 1'b0;
      instr(8'h8E, 1'b0);
      @(negedge i_clock);
      cmp_val("frozen halt", 4'h0, {1'b0, o_mode});
      cmp_val("frozen mask", {2'h0, r[1:0]}, {2'h0, o_cc_mask});
      i_clk_en = 1'b1;
      $display("test wait done");
      i_watchdog_active = 1'b1;
      i_osc_irq_enable = 1'b1;
      instr(8'h8E, 1'b0);
      cmp_val("active halt mode", 4'h2, {1'b0, o_mode});
      cmp_val("active halt clocks", 4'h5, {1'b0, o_timebase_clk_en, o_periph_clk_en, o_osc_en});
      cmp_val("no watchdog reset", 4'h0, {3'h0, o_watchdog_reset_req});
      raise = 10'h040 << r[3:2];
      @(negedge i_clock);
      raise = 10'h000;
      repeat (2) @(negedge i_clock);
      cmp_val("ignored source", 4'h2, {1'b0, o_mode});
      wake(10'h001, 2);
      repeat (SC) @(negedge i_clock);
      cmp_val("enable kept", 4'h0, {1'b0, o_mode});
      instr(8'h8E, 1'b0);
      wake(10'h002 << r[5:4], 2);
      i_osc_irq_enable = 1'b0;
      @(negedge i_clock);
      cmp_val("halt remaining", 4'h5, {1'b0, o_mode});
      cmp_val("osc off", 4'h0, {3'h0, o_osc_en});
      wait_run();
      cmp_val("back to run", 4'h0, {1'b0, o_mode});
      $display("test active halt done");
      instr(8'h8E, 1'b0);
      cmp_val("watchdog reset", 4'h1, {3'h0, o_watchdog_reset_req});
      cmp_val("stays run", 4'h0, {1'b0, o_mode});
      i_watchdog_halt_option = 1'b1;
      i_long_startup = 1'b1;
      @(negedge i_clock);  // idle cycle so the strobe is lowered before it is raised again
      instr(8'h8E, 1'b0);
      cmp_val("halt mode", 4'h3, {1'b0, o_mode});
      cmp_val("halt clocks", 4'h0, {1'b0, o_timebase_clk_en, o_periph_clk_en, o_osc_en});
      cmp_val("halt mask", 4'h2, {2'h0, o_cc_mask});
      raise = 10'h3C1;
      @(negedge i_clock);
      raise = 10'h000;
      repeat (2) @(negedge i_clock);
      cmp_val("halt ignores", 4'h3, {1'b0, o_mode});
      flush = 1'b1;
      @(negedge i_clock);
      flush = 1'b0;
      r = 10'($random(seed));
      wake((r & 10'h03E) | 10'h020, LC + 2);
      raise = 10'h008;
      @(negedge i_clock);
      raise = 10'h000;
      @(negedge i_clock);
      exp_idx.push_back(3);  // model: ext2 already pending when halt executes
      instr(8'h8E, 1'b0);
      cmp_val("pending wake", 4'h3, o_irq_index);
      cmp_val("pending mode", 4'h0, {1'b0, o_mode});
      @(negedge i_clock);
      cmp_val("model drained", 4'h0, 4'(exp_idx.size()));
      $display("test halt done");
      end_of_test();
   end
endmodule : low_power_mode_controller_bench
`default_nettype wire
